/* File: asp_pkg.sv */
// constants and state encoding for the asynchronous static memory host port
package asp_pkg;
	// array geometry and counter width
	localparam int ADDR_W = 17;
	localparam int DATA_W = 8;
	localparam int CNT_W = 5;
	// clock period and pin timing figures in ns
	localparam int CLK_NS = 5;
	localparam int T_AA_NS = 70;
	localparam int T_DOE_NS = 35;
	localparam int T_AW_NS = 60;
	localparam int T_PWE_NS = 50;
	localparam int T_SD_NS = 30;
	localparam int T_HZOE_NS = 25;
	localparam int T_WC_NS = 70;
	// synchroniser depth on the data pins
	localparam int SYNC_STAGES = 2;
	// least times rounded up to whole cycles
	localparam int RD_CYC_I = (T_AA_NS + CLK_NS - 1) / CLK_NS;
	localparam int DOE_CYC_I = (T_DOE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WR_LOW_CYC_I = (T_AW_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWE_CYC_I = (T_PWE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SD_CYC_I = (T_SD_NS + CLK_NS - 1) / CLK_NS;
	localparam int HZ_CYC_I = (T_HZOE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WC_CYC_I = (T_WC_NS + CLK_NS - 1) / CLK_NS;
	// counter targets at counter width
	localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(RD_CYC_I + SYNC_STAGES);
	localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(RD_CYC_I);
	localparam logic [CNT_W-1:0] DOE_CYC = CNT_W'(DOE_CYC_I);
	localparam logic [CNT_W-1:0] WR_LOW_CYC = CNT_W'(WR_LOW_CYC_I);
	localparam logic [CNT_W-1:0] PWE_CYC = CNT_W'(PWE_CYC_I);
	localparam logic [CNT_W-1:0] SD_CYC = CNT_W'(SD_CYC_I);
	localparam logic [CNT_W-1:0] HZ_CYC = CNT_W'(HZ_CYC_I);
	localparam logic [CNT_W-1:0] WC_CYC = CNT_W'(WC_CYC_I);
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	// bus idle values
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h00000;
	// one-hot sequencer states
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RD = 6'h02,
		ST_TURN = 6'h04,
		ST_WR_SET = 6'h08,
		ST_WR_LOW = 6'h10,
		ST_WR_HOLD = 6'h20
	} asp_state_t;
endpackage

/* File: asp_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module asp_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// raw pin and synchronised level
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_r <= '0;
			dout <= '0;
		end
		else
		begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* File: asp_host.sv */
// host sequencer driving an asynchronous 128k x 8 static memory over its pins
// Operation
// R01 - memory has 128K bytes, 17-bit address, 8-bit shared data bus
// R02 - write: low select low, high select high, strobe low, byte stored
// R03 - read: low select and output drive low, strobe and high select high
// R04 - device floats bus when deselected, output disabled, or writing
// R05 - output drive low makes pins outputs; high makes them write inputs
// R06 - deselected device drops to standby whatever other controls do
// R07 - internal write lasts while both selects and strobe are all active
// R08 - write ends when first of the three qualifying signals goes inactive
// R09 - host times data setup and hold to the edge ending the write
// R10 - deselect with strobe rising keeps bus floating, no read glitch
// R11 - strobe writes with output drive on need strobe low setup plus float
// R12 - read data valid at most 70 ns after stable address
// R13 - read data valid at most 35 ns after output drive goes low
// R14 - host releases its data drivers while it enables device output drive
`timescale 1ns/10ps
`default_nettype none
module asp_host (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// user request
	input wire logic req,
	input wire logic req_wr,
	input wire logic [asp_pkg::ADDR_W-1:0] req_addr,
	input wire logic [asp_pkg::DATA_W-1:0] req_wdata,
	output logic ready,
	// user answer
	output logic [asp_pkg::DATA_W-1:0] rd_data,
	output logic rd_valid,
	output logic wr_done,
	// memory control pins
	output logic [asp_pkg::ADDR_W-1:0] sram_addr,
	output logic sram_ce1_b,
	output logic sram_ce2,
	output logic sram_oe_b,
	output logic sram_we_b,
	// memory data pins
	output logic [asp_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe_b,
	input wire logic [asp_pkg::DATA_W-1:0] dq_in
);
	import asp_pkg::*;

	asp_state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [DATA_W-1:0] dq_sync;
	logic [CNT_W-1:0] we_low_cnt_r;
	logic [CNT_W-1:0] oe_low_cnt_r;

	// data pins come from outside the clock domain
	asp_sync #(
		.W(DATA_W)
	) u_dq_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.din(dq_in),
		.dout(dq_sync)
	);

	// new requests only when idle
	assign ready = (state_r == ST_IDLE);

	// sequencer and its cycle counter
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= ST_IDLE;
			cnt_r <= CNT_ZERO;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					cnt_r <= CNT_ZERO;
					if (req && req_wr)
						state_r <= ST_WR_SET;
					else if (req)
						state_r <= ST_RD;
				end
				ST_RD:
				begin
					cnt_r <= cnt_r + CNT_ONE;
					if (cnt_r == RD_WAIT) // R12 R13
					begin
						state_r <= ST_TURN;
						cnt_r <= CNT_ZERO;
					end
				end
				ST_TURN:
				begin
					cnt_r <= cnt_r + CNT_ONE;
					if (cnt_r == HZ_CYC - CNT_ONE) // R14
						state_r <= ST_IDLE;
				end
				ST_WR_SET:
				begin
					cnt_r <= CNT_ZERO;
					state_r <= ST_WR_LOW;
				end
				ST_WR_LOW:
				begin
					cnt_r <= cnt_r + CNT_ONE;
					if (cnt_r == WR_LOW_CYC - CNT_ONE) // R07
						state_r <= ST_WR_HOLD;
				end
				ST_WR_HOLD:
					state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// address latched at request and held through the access
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			sram_addr <= ADDR_ZERO;
		else if (ready && req)
			sram_addr <= req_addr; // R01
	end

	// selects: active from request to end of access, idle otherwise
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sram_ce1_b <= 1'b1;
			sram_ce2 <= 1'b0;
		end
		else if (ready && req)
		begin
			sram_ce1_b <= 1'b0;
			sram_ce2 <= 1'b1;
		end
		else if ((state_r == ST_RD && cnt_r == RD_WAIT) || state_r == ST_WR_HOLD)
		begin
			sram_ce1_b <= 1'b1; // R06
			sram_ce2 <= 1'b0;
		end
	end

	// output drive low only for reads, held high through writes
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			sram_oe_b <= 1'b1;
		else if (ready && req && !req_wr)
			sram_oe_b <= 1'b0; // R03 R13
		else if (state_r == ST_RD && cnt_r == RD_WAIT)
			sram_oe_b <= 1'b1; // R04 R05 R11
	end

	// write strobe: low for the whole pulse, raised before the selects
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			sram_we_b <= 1'b1;
		else if (state_r == ST_WR_SET)
			sram_we_b <= 1'b0; // R02
		else if (state_r == ST_WR_LOW && cnt_r == WR_LOW_CYC - CNT_ONE)
			sram_we_b <= 1'b1; // R08
	end

	// host data drive: on for writes only, held one cycle past strobe rise
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dq_out <= DATA_ZERO;
			dq_oe_b <= 1'b1;
		end
		else if (ready && req && req_wr)
		begin
			dq_out <= req_wdata;
			dq_oe_b <= 1'b0; // R14
		end
		else if (state_r == ST_WR_HOLD)
			dq_oe_b <= 1'b1; // R09
	end

	// read capture: pins first sampled one edge past the access time, then synced
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_data <= DATA_ZERO;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= 1'b0;
			if (state_r == ST_RD && cnt_r == RD_WAIT)
			begin
				rd_data <= dq_sync; // R12
				rd_valid <= 1'b1;
			end
		end
	end

	// write completion pulse
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			wr_done <= 1'b0;
		else
			wr_done <= (state_r == ST_WR_HOLD);
	end

	// helper counters for the checks below
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			we_low_cnt_r <= CNT_ZERO;
			oe_low_cnt_r <= CNT_ZERO;
		end
		else
		begin
			we_low_cnt_r <= sram_we_b ? CNT_ZERO : we_low_cnt_r + CNT_ONE;
			oe_low_cnt_r <= sram_oe_b ? CNT_ZERO : oe_low_cnt_r + CNT_ONE;
		end
	end

	// never drive the bus while the device may drive it
	property p_no_contention;
		@(posedge mclk) disable iff (!rst_b)
		!dq_oe_b |-> sram_oe_b;
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("host drives while oe low"); // R14

	// strobe low only with both selects active and output drive off
	property p_write_qual;
		@(posedge mclk) disable iff (!rst_b)
		!sram_we_b |-> !sram_ce1_b && sram_ce2 && sram_oe_b && !dq_oe_b;
	endproperty
	a_write_qual: assert property (p_write_qual) else $error("write strobe without selects"); // R02 R05

	// read only with strobe high and both selects active
	property p_read_qual;
		@(posedge mclk) disable iff (!rst_b)
		!sram_oe_b |-> sram_we_b && !sram_ce1_b && sram_ce2;
	endproperty
	a_read_qual: assert property (p_read_qual) else $error("read enable with bad controls"); // R03

	// strobe low long enough for address, pulse and data setup
	property p_pulse_len;
		@(posedge mclk) disable iff (!rst_b)
		$rose(sram_we_b) |-> we_low_cnt_r >= WR_LOW_CYC && we_low_cnt_r >= PWE_CYC
			&& we_low_cnt_r >= SD_CYC;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("write pulse too short"); // R07

	// strobe ends the write while selects and data still stand
	sequence s_wr_end;
		$rose(sram_we_b);
	endsequence
	sequence s_wr_tail;
		!sram_ce1_b && sram_ce2 && !dq_oe_b && $stable(dq_out) ##1 sram_ce1_b && !sram_ce2;
	endsequence
	property p_wr_end;
		@(posedge mclk) disable iff (!rst_b)
		s_wr_end |-> s_wr_tail;
	endproperty
	a_wr_end: assert property (p_wr_end) else $error("write end ordering wrong"); // R08 R09

	// no read drive around the end of a write
	property p_wr_float;
		@(posedge mclk) disable iff (!rst_b)
		s_wr_end |-> sram_oe_b[*2];
	endproperty
	a_wr_float: assert property (p_wr_float) else $error("oe low at write end"); // R10

	// capture only after address and output drive times elapsed
	property p_rd_time;
		@(posedge mclk) disable iff (!rst_b)
		rd_valid |-> $past(oe_low_cnt_r) >= RD_CYC + CNT_ONE && $past(oe_low_cnt_r) >= DOE_CYC;
	endproperty
	a_rd_time: assert property (p_rd_time) else $error("read captured too early"); // R12 R13

	// bus stays released for the float time after a read
	property p_turn;
		@(posedge mclk) disable iff (!rst_b)
		$rose(sram_oe_b) |-> dq_oe_b[*5];
	endproperty
	a_turn: assert property (p_turn) else $error("drive too soon after read"); // R14

	// host entering idle has the device deselected, strobe and output drive high
	property p_idle;
		@(posedge mclk) disable iff (!rst_b)
		ready && !$past(ready) |-> sram_ce1_b && !sram_ce2 && sram_we_b && sram_oe_b;
	endproperty
	a_idle: assert property (p_idle) else $error("device selected while idle"); // R06

	// address steady while selected
	property p_addr_hold;
		@(posedge mclk) disable iff (!rst_b)
		!sram_ce1_b && $past(!sram_ce1_b) |-> $stable(sram_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved while selected"); // R01
endmodule
`default_nettype wire

/* File: asp_sram_model.sv */
// behavioural 128k x 8 static memory facing the host port
`timescale 1ns/10ps
`default_nettype none
module asp_sram_model #(
	parameter int RD_NS = 70,
	parameter int OE_NS = 35
) (
	// memory control pins
	input wire logic [asp_pkg::ADDR_W-1:0] addr,
	input wire logic ce1_b,
	input wire logic ce2,
	input wire logic oe_b,
	input wire logic we_b,
	// shared data bus
	input wire logic [asp_pkg::DATA_W-1:0] dq_out,
	input wire logic dq_oe_b,
	output logic [asp_pkg::DATA_W-1:0] dq_in,
	// count of host timing breaches
	output int viol
);
	import asp_pkg::*;
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] noise = 8'h5a;
	logic [DATA_W-1:0] dev_q;
	logic rd_on;
	logic wr_on;
	realtime t_a, t_oe, t_d, t_w;
	initial viol = 0;
	// a floating bus shows a moving pattern, never the last byte
	always #1 noise = noise + 8'h3b;
	// drive only when selected, enabled and not writing
	assign rd_on = !ce1_b && ce2 && !oe_b && we_b;
	assign wr_on = !ce1_b && ce2 && !we_b;
	assign dq_in = !dq_oe_b ? dq_out : (rd_on ? dev_q : noise);
	// event times for the access delays
	always @(addr or ce1_b or ce2) t_a = $realtime;
	always @(negedge oe_b) t_oe = $realtime;
	always @(dq_out or dq_oe_b) t_d = $realtime;
	always @(posedge wr_on) t_w = $realtime;
	// read byte is garbage until both delays have run out
	always @*
	begin
		dev_q = noise;
		if (rd_on && $realtime - t_a >= RD_NS && $realtime - t_oe >= OE_NS)
			dev_q = mem[addr];
	end
	// store on whichever edge ends the write
	always @(negedge wr_on)
		if (t_w > 0) // skips the power-up step from unknown to low
		begin
			if ($realtime - t_d < T_SD_NS || dq_oe_b) viol++;
			if ($realtime - t_w < T_PWE_NS) viol++;
			mem[addr] = dq_out;
		end
	// host must not drive against read data
	always @(rd_on or dq_oe_b)
		if (rd_on && !dq_oe_b) viol++;
endmodule
`default_nettype wire

/* File: asp_host_tb_top.sv */
// self-checking bench for the static memory host port
`timescale 1ns/10ps
`default_nettype none
module asp_host_tb_top;
	import asp_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic req = 1'b0;
	logic req_wr = 1'b0;
	logic [ADDR_W-1:0] req_addr = 17'h00000;
	logic [DATA_W-1:0] req_wdata = 8'h00;
	logic ready, rd_valid, wr_done, ce1_b, ce2, oe_b, we_b, dq_oe_b;
	logic [DATA_W-1:0] rd_data, dq_out, dq_in;
	logic [ADDR_W-1:0] sram_addr;
	int num_errors = 0;
	int n_tests = 0;
	int viol;
	int k;
	// cycles from request edge to answer and to ready again
	localparam int WR_K = WR_LOW_CYC_I + 2;
	localparam int RD_K = RD_CYC_I + 1 + SYNC_STAGES;
	localparam int RDY_K = RD_K + HZ_CYC_I;
	// clock
	initial forever #2.5 mclk = ~mclk;
	asp_host i_dut (.mclk(mclk), .rst_b(rst_b), .req(req), .req_wr(req_wr),
		.req_addr(req_addr), .req_wdata(req_wdata), .ready(ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .wr_done(wr_done), .sram_addr(sram_addr), .sram_ce1_b(ce1_b),
		.sram_ce2(ce2), .sram_oe_b(oe_b), .sram_we_b(we_b), .dq_out(dq_out),
		.dq_oe_b(dq_oe_b), .dq_in(dq_in));
	asp_sram_model i_mem (.addr(sram_addr), .ce1_b(ce1_b), .ce2(ce2), .oe_b(oe_b),
		.we_b(we_b), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .dq_in(dq_in), .viol(viol));
	// compare one value
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// verdict
	task automatic wrap_up;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// one request from a falling edge, answer and ready timed
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		chk(ready, 1'b1);
		req = 1'b1;
		req_wr = w;
		req_addr = a;
		req_wdata = d;
		@(negedge mclk);
		req = 1'b0;
		k = 0;
		while ((w ? wr_done : rd_valid) !== 1'b1 && k < 40)
		begin
			@(negedge mclk);
			k++;
		end
		chk(k, w ? WR_K : RD_K);
		while (ready !== 1'b1 && k < 40)
		begin
			@(negedge mclk);
			k++;
		end
		chk(k, w ? WR_K : RDY_K);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		xfer(1'b0, a, 8'h00);
		chk(rd_data, e);
	endtask
	function automatic logic [ADDR_W-1:0] adr(input int i);
		return (i < 17) ? 17'h00001 << i : (i == 17 ? 17'h00000 : 17'h1ffff);
	endfunction
	// pin relations during every access
	always @(negedge mclk)
	begin
		if (!we_b) chk({oe_b, ce1_b, ce2, dq_oe_b}, 4'ha);
		if (!oe_b) chk({ce1_b, ce2, we_b, dq_oe_b}, 4'h7);
	end
	// idle pins while reset holds
	task automatic t_reset;
		chk({ready, rd_valid, wr_done, ce1_b, ce2, oe_b, we_b, dq_oe_b}, 8'h97);
		chk({sram_addr, rd_data}, 25'h0000000);
	endtask
	// every address line and both ends, back to back
	task automatic t_walk;
		for (int i = 0; i < 19; i++) xfer(1'b1, adr(i), 8'(i * 29 + 3));
		for (int i = 0; i < 19; i++) rd(adr(i), 8'(i * 29 + 3));
	endtask
	// stray request while busy is ignored
	task automatic t_refused;
		fork
			xfer(1'b1, 17'h00008, 8'hc3);
			begin
				repeat (5) @(negedge mclk);
				chk(ready, 1'b0);
				req = 1'b1;
				req_addr = 17'h00004;
				req_wdata = 8'h3c;
				@(negedge mclk);
				req = 1'b0;
			end
		join
		rd(17'h00004, 8'(2 * 29 + 3));
		rd(17'h00008, 8'hc3);
	endtask
	// reset in mid-read drops the pins to idle
	task automatic t_reset_mid;
		req = 1'b1;
		req_addr = 17'h1ffff;
		@(negedge mclk);
		req = 1'b0;
		repeat (6) @(negedge mclk);
		rst_b = 1'b0;
		@(negedge mclk);
		t_reset();
		rst_b = 1'b1;
		@(negedge mclk);
		rd(17'h1ffff, 8'(18 * 29 + 3));
	endtask
	initial
	begin
		repeat (2) @(negedge mclk);
		t_reset();
		rst_b = 1'b1;
		@(negedge mclk);
		t_walk();
		t_refused();
		t_reset_mid();
		chk(viol, 0);
		wrap_up();
	end
	// watchdog
	initial
	begin
		#20000;
		num_errors++;
		wrap_up();
	end
endmodule
`default_nettype wire
